// *** design/audio_port_defs.svh ***
// Offsets, reset values, field positions and timing counts of the audio port
`ifndef AUDIO_PORT_DEFS_SVH
`define AUDIO_PORT_DEFS_SVH

// Register byte offsets
`define AP_CTRL_OFF    12'h000
`define AP_MAP_OFF     12'h004
`define AP_STATUS_OFF  12'h008
`define AP_TX0_OFF     12'h00c
`define AP_TX1_OFF     12'h010
`define AP_TX2_OFF     12'h014
`define AP_RX0_OFF     12'h018
`define AP_RX1_OFF     12'h01c
`define AP_RX2_OFF     12'h020

// Reset values
`define AP_CTRL_RST    17'h00000
`define AP_MAP_RST     15'h0000
`define AP_TX_RST      16'h0000

// Field layout
`define AP_CTRL_W      17
`define AP_MAP_W       15
`define AP_MAP_CH_W    5
`define AP_MAP_EN_BIT  4
`define AP_STAT_CNT_LO 16
`define AP_SLOT_LG_MAX 3'h4
`define AP_WORD_BITS   16
`define AP_PAD_BITS    3
`define AP_LONG_SYNC   8'h03

// Timing
`define AP_CLK_HZ       50000000
`define AP_BASE_BIT_HZ  128000
`define AP_BURST_MAX_HZ 24000000
`define AP_NB_HALF  ((`AP_CLK_HZ) / (2 * `AP_BASE_BIT_HZ))
`define AP_BURST_HALF \
    ((`AP_CLK_HZ + 2 * `AP_BURST_MAX_HZ - 1) / (2 * `AP_BURST_MAX_HZ))

`endif

// *** design/audio_port_pkg.sv ***
// Types shared by the audio serial port
package audio_port_pkg;

    typedef enum logic [1:0] {
        FILL_ZERO = 2'b00,
        FILL_ONE  = 2'b01,
        FILL_SIGN = 2'b10,
        FILL_PROG = 2'b11
    } fill_e;

    typedef enum logic [1:0] {
        LNK_IDLE = 2'b00,
        LNK_HUNT = 2'b01,
        LNK_RUN  = 2'b10
    } link_e;

    typedef struct packed {
        logic [2:0] fill_val;
        fill_e      fill;
        logic [1:0] offset;
        logic       lsb_first;
        logic [2:0] slots_lg;
        logic       wide;
        logic       burst;
        logic       long_sync;
        logic       master;
        logic       pcm;
        logic       en;
    } ctrl_s;

endpackage : audio_port_pkg

// *** design/pin_sync3.sv ***
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module pin_sync3 #(
    parameter int W = 3
) (
    // Clock and reset
    input  wire logic         clk_in,
    input  wire logic         sys_rst_in,
    // Pins and filtered levels
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] lvl_out,
    output logic      [W-1:0] rise_out,
    output logic      [W-1:0] fall_out
);
    typedef struct packed {
        logic [W-1:0] f1;
        logic [W-1:0] f2;
        logic [W-1:0] f3;
        logic [W-1:0] lvl;
    } sync_s;

    sync_s st_r;
    sync_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.f1 = pin_in;
        st_nxt.f2 = st_r.f1;
        st_nxt.f3 = st_r.f2;
        // A change counts once the second and third stages agree
        st_nxt.lvl = (st_r.f2 & st_r.f3) | (st_r.lvl & (st_r.f2 ^ st_r.f3));
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign lvl_out  = st_nxt.lvl;
    assign rise_out = st_nxt.lvl & ~st_r.lvl;
    assign fall_out = ~st_nxt.lvl & st_r.lvl;

endmodule : pin_sync3

// *** design/audio_serial_port.sv ***
// Shared I2S / PCM serial audio port with APB register access
//
// Operation
// - Master drives bit clock and word select; slave takes them in.
// - I2S channel words are sixteen bits, MSB aligned per I2S.
// - I2S word MSB goes out one bit after word select changes.
// - Left word while word select low, right word while high.
// - I2S data changes on falling clock, sampled on rising clock.
// - One shared unit; configuration selects I2S or PCM, never both.
// - PCM master makes clock and sync; slave takes both as inputs.
// - Up to three voice channels share up to sixteen slots per sample.
// - Slot count follows the chosen bit rate, up to sixteen.
// - Each channel sends and receives in the same slot.
// - Data driver floats during slots no active channel uses.
// - Driver releases after falling clock in the slot's last bit.
// - Short and long sync both work as master and as slave.
// - Short sync is a one-bit high pulse aligned to rising clock.
// - Short-sync slave sees sync on falling edge, slot zero next rise.
// - Long sync lasts three bits, starting with slot zero's first bit.
// - Narrowband slots carry thirteen bits, placement and order set.
// - Spare bits ignored on receive, filled as configured on send.
// - Reset format: 13-bit two's complement, MSB end, MSB first.
// - Burst mode runs the PCM bus fast, at most 24 MHz.
`timescale 1ns/1ps
`include "audio_port_defs.svh"
module audio_serial_port #(
    parameter logic [7:0] NB_HALF    = 8'(`AP_NB_HALF),
    parameter logic [7:0] BURST_HALF = 8'(`AP_BURST_HALF)
) (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    // APB slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // Bit clock pin
    input  wire logic        sck_in,
    output logic             sck_out,
    output logic             sck_oe_out,
    // Word select / frame sync pin
    input  wire logic        ws_in,
    output logic             ws_out,
    output logic             ws_oe_out,
    // Serial data pins
    input  wire logic        din_in,
    output logic             dout_out,
    output logic             dout_oe_out
);
    typedef struct packed {
        audio_port_pkg::ctrl_s  ctrl;
        logic [14:0]            map;
        logic [2:0][15:0]       tx;
        logic [2:0][15:0]       rx;
        audio_port_pkg::link_e  link;
        logic [31:0]            rdata;
        logic [7:0]             div;
        logic                   sck;
        logic                   ws;
        logic                   dout;
        logic                   doe;
        logic [7:0]             pos;
        logic [15:0]            sh;
        logic                   pend;
        logic                   pend_long;
        logic                   ws_prev;
        logic                   fs_prev;
        logic                   hit;
        logic [1:0]             ch;
        logic [15:0]            frames;
    } core_s;

    core_s st_r;
    core_s st_nxt;

    logic [2:0] pin_lvl;
    logic [2:0] pin_rise;
    logic [2:0] pin_fall;

    pin_sync3 #(
        .W (3)
    ) u_sync (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .pin_in     ({din_in, ws_in, sck_in}),
        .lvl_out    (pin_lvl),
        .rise_out   (pin_rise),
        .fall_out   (pin_fall)
    );

    function automatic logic addr_ok(input logic [11:0] a);
        case (a)
            `AP_CTRL_OFF, `AP_MAP_OFF, `AP_STATUS_OFF,
            `AP_TX0_OFF, `AP_TX1_OFF, `AP_TX2_OFF,
            `AP_RX0_OFF, `AP_RX1_OFF, `AP_RX2_OFF: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    endfunction : addr_ok

    // Half bit period in system clocks for master operation
    function automatic logic [7:0] half_of(input audio_port_pkg::ctrl_s c);
        logic [7:0] h;
        h = NB_HALF >> c.wide;
        if (c.burst && c.pcm) begin
            h = BURST_HALF;
        end else if (c.pcm) begin
            h = h >> c.slots_lg;
        end else begin
            h = h >> 1;
        end
        if (h == 8'h00) begin
            h = 8'h01;
        end
        half_of = h;
    endfunction : half_of

    // Bit index within a slot word for a given bit time
    function automatic logic [3:0] bit_idx(input logic lsb, input logic [3:0] b);
        bit_idx = lsb ? b : ~b;
    endfunction : bit_idx

    // Build a transmit slot word from a 13-bit sample
    function automatic logic [15:0] fmt_tx(input audio_port_pkg::ctrl_s c,
                                           input logic [15:0] s);
        logic [2:0]  pad;
        logic [18:0] full;
        case (c.fill)
            audio_port_pkg::FILL_ZERO: pad = 3'h0;
            audio_port_pkg::FILL_ONE:  pad = 3'h7;
            audio_port_pkg::FILL_SIGN: pad = {3{s[12]}};
            default:                   pad = c.fill_val;
        endcase
        full = {pad, s[12:0], pad};
        fmt_tx = 16'(full >> c.offset);
    endfunction : fmt_tx

    // Extract the 13-bit sample from a received slot word
    function automatic logic [15:0] fmt_rx(input audio_port_pkg::ctrl_s c,
                                           input logic [15:0] w);
        logic [1:0] k;
        k = 2'h3 - c.offset;
        fmt_rx = {3'h0, 13'(w >> k)};
    endfunction : fmt_rx

    // First enabled channel mapped to a slot
    function automatic logic [2:0] slot_hit(input logic [14:0] m,
                                            input logic [3:0] slot);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 2; i >= 0; i--) begin
            if (m[i*`AP_MAP_CH_W + `AP_MAP_EN_BIT] &&
                m[i*`AP_MAP_CH_W +: 4] == slot) begin
                r = {1'b1, 2'(i)};
            end
        end
        slot_hit = r;
    endfunction : slot_hit

    logic       acc;
    logic       rise;
    logic       fall;
    logic       ws_lvl;
    logic       fs_sync;
    logic [7:0] half;
    logic [7:0] nb;
    logic [7:0] last;
    logic [2:0] sh_r;
    logic [3:0] bi;
    logic [15:0] word;
    logic [15:0] shv;
    audio_port_pkg::ctrl_s wc;

    always_comb begin
        st_nxt = st_r;
        acc = psel_in & penable_in & addr_ok(paddr_in);
        rise = 1'b0;
        fall = 1'b0;
        nb = st_r.pos;
        sh_r = 3'h0;
        bi = 4'h0;
        word = 16'h0000;
        shv = st_r.sh;
        fs_sync = 1'b0;
        wc = audio_port_pkg::ctrl_s'(pwdata_in[`AP_CTRL_W-1:0]);
        if (wc.slots_lg > `AP_SLOT_LG_MAX) begin
            wc.slots_lg = `AP_SLOT_LG_MAX;
        end
        last = 8'((16'h0010 << st_r.ctrl.slots_lg) - 16'h0001);
        half = half_of(st_r.ctrl);

        // Read data captured in the setup cycle
        if (psel_in && !penable_in) begin
            case (paddr_in)
                `AP_CTRL_OFF:   st_nxt.rdata = 32'(st_r.ctrl);
                `AP_MAP_OFF:    st_nxt.rdata = 32'(st_r.map);
                `AP_STATUS_OFF: st_nxt.rdata = {st_r.frames, 14'h0000,
                                                st_r.link};
                `AP_TX0_OFF:    st_nxt.rdata = 32'(st_r.tx[0]);
                `AP_TX1_OFF:    st_nxt.rdata = 32'(st_r.tx[1]);
                `AP_TX2_OFF:    st_nxt.rdata = 32'(st_r.tx[2]);
                `AP_RX0_OFF:    st_nxt.rdata = 32'(st_r.rx[0]);
                `AP_RX1_OFF:    st_nxt.rdata = 32'(st_r.rx[1]);
                `AP_RX2_OFF:    st_nxt.rdata = 32'(st_r.rx[2]);
                default:        st_nxt.rdata = 32'h00000000;
            endcase
        end
        if (acc && pwrite_in) begin
            case (paddr_in)
                `AP_CTRL_OFF: st_nxt.ctrl = wc;
                `AP_MAP_OFF:  st_nxt.map = pwdata_in[`AP_MAP_W-1:0];
                `AP_TX0_OFF:  st_nxt.tx[0] = pwdata_in[15:0];
                `AP_TX1_OFF:  st_nxt.tx[1] = pwdata_in[15:0];
                `AP_TX2_OFF:  st_nxt.tx[2] = pwdata_in[15:0];
                default:      st_nxt.ctrl = st_r.ctrl;
            endcase
        end

        // Bit clock: own divider as master, filtered pin as slave
        if (st_r.ctrl.master) begin
            if (st_r.div >= half - 8'h01) begin
                st_nxt.div = 8'h00;
                st_nxt.sck = ~st_r.sck;
                rise = ~st_r.sck;
                fall = st_r.sck;
            end else begin
                st_nxt.div = st_r.div + 8'h01;
            end
            ws_lvl = st_r.ws;
        end else begin
            rise = pin_rise[0];
            fall = pin_fall[0];
            ws_lvl = pin_lvl[1];
        end

        case (st_r.link)
            audio_port_pkg::LNK_IDLE: begin
                st_nxt.pos = 8'h00;
                st_nxt.pend = 1'b0;
                st_nxt.doe = 1'b0;
                if (st_r.ctrl.en) begin
                    st_nxt.link = audio_port_pkg::LNK_HUNT;
                end
            end
            audio_port_pkg::LNK_HUNT, audio_port_pkg::LNK_RUN: begin
                if (!st_r.ctrl.pcm) begin
                    // I2S: launch on falling edge
                    if (fall) begin
                        nb = st_r.pend ? {3'h0, st_r.ws_prev, 4'h0}
                                       : {3'h0, 5'(st_r.pos + 8'h01)};
                        st_nxt.pos = nb;
                        st_nxt.pend = 1'b0;
                        if (st_r.ctrl.master) begin
                            st_nxt.ws = 1'(5'(nb + 8'h01) >> 4);
                        end
                        // Left while word select low, right while high
                        st_nxt.dout = st_r.tx[nb[4]][~nb[3:0]];
                        st_nxt.doe = 1'b1;
                    end
                    // I2S: capture on rising edge
                    if (rise) begin
                        if (ws_lvl != st_r.ws_prev) begin
                            st_nxt.pend = 1'b1;
                            st_nxt.link = audio_port_pkg::LNK_RUN;
                        end
                        st_nxt.ws_prev = ws_lvl;
                        shv[~st_r.pos[3:0]] = pin_lvl[2];
                        st_nxt.sh = shv;
                        if (st_r.pos[3:0] == 4'hf &&
                            st_r.link == audio_port_pkg::LNK_RUN) begin
                            st_nxt.rx[st_r.pos[4]] = shv;
                            if (st_r.pos[4]) begin
                                st_nxt.frames = st_r.frames + 16'h0001;
                            end
                        end
                    end
                end else begin
                    // PCM: launch on rising edge
                    if (rise) begin
                        if (st_r.pend) begin
                            nb = st_r.pend_long ? 8'h01 : 8'h00;
                        end else if (st_r.pos >= last) begin
                            nb = 8'h00;
                        end else begin
                            nb = st_r.pos + 8'h01;
                        end
                        st_nxt.pos = nb;
                        st_nxt.pend = 1'b0;
                        if (st_r.ctrl.master) begin
                            st_nxt.ws = st_r.ctrl.long_sync
                                      ? (nb < `AP_LONG_SYNC)
                                      : (nb == last);
                        end
                        sh_r = slot_hit(st_r.map, nb[7:4]);
                        st_nxt.hit = sh_r[2];
                        st_nxt.ch = sh_r[1:0];
                        word = fmt_tx(st_r.ctrl, st_r.tx[sh_r[1:0]]);
                        bi = bit_idx(st_r.ctrl.lsb_first, nb[3:0]);
                        st_nxt.dout = word[bi];
                        // Float on slots no channel owns
                        st_nxt.doe = sh_r[2] &&
                            st_r.link == audio_port_pkg::LNK_RUN;
                        if (nb == 8'h00 &&
                            st_r.link == audio_port_pkg::LNK_RUN) begin
                            st_nxt.frames = st_r.frames + 16'h0001;
                        end
                    end
                    // PCM: sync detect and capture on falling edge
                    if (fall) begin
                        fs_sync = st_r.ctrl.long_sync
                                ? (ws_lvl & ~st_r.fs_prev) : ws_lvl;
                        st_nxt.fs_prev = ws_lvl;
                        if (fs_sync) begin
                            st_nxt.pend = 1'b1;
                            st_nxt.pend_long = st_r.ctrl.long_sync;
                            st_nxt.link = audio_port_pkg::LNK_RUN;
                        end
                        if (st_r.hit &&
                            st_r.link == audio_port_pkg::LNK_RUN) begin
                            bi = bit_idx(st_r.ctrl.lsb_first, st_r.pos[3:0]);
                            shv[bi] = pin_lvl[2];
                            st_nxt.sh = shv;
                            if (st_r.pos[3:0] == 4'hf) begin
                                // Same slot in both directions
                                st_nxt.rx[st_r.ch] = fmt_rx(st_r.ctrl, shv);
                            end
                        end
                        if (st_r.pos[3:0] == 4'hf) begin
                            st_nxt.doe = 1'b0;
                        end
                    end
                end
                if (!st_r.ctrl.en) begin
                    st_nxt.link = audio_port_pkg::LNK_IDLE;
                    st_nxt.sck = 1'b0;
                    st_nxt.ws = 1'b0;
                    st_nxt.div = 8'h00;
                end
            end
            default: begin
                st_nxt.link = audio_port_pkg::LNK_IDLE;
            end
        endcase

        // Mode change drops lock so the new mode resynchronises
        if (acc && pwrite_in && paddr_in == `AP_CTRL_OFF &&
            (wc.pcm != st_r.ctrl.pcm || wc.master != st_r.ctrl.master)) begin
            st_nxt.link = audio_port_pkg::LNK_IDLE;
            st_nxt.doe = 1'b0;
            st_nxt.sck = 1'b0;
            st_nxt.ws = 1'b0;
            st_nxt.div = 8'h00;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st_r <= '0;
            st_r.ctrl <= audio_port_pkg::ctrl_s'(`AP_CTRL_RST);
            st_r.map <= `AP_MAP_RST;
            st_r.tx <= {3{`AP_TX_RST}};
            st_r.link <= audio_port_pkg::LNK_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Pin drivers
    assign sck_out     = st_r.sck;
    assign sck_oe_out  = st_r.ctrl.en & st_r.ctrl.master;
    assign ws_out      = st_r.ws;
    assign ws_oe_out   = st_r.ctrl.en & st_r.ctrl.master;
    assign dout_out    = st_r.dout;
    assign dout_oe_out = st_r.doe;

    // APB answers in its access cycle with no wait states
    assign prdata_out  = st_r.rdata;
    assign pready_out  = 1'b1;
    assign pslverr_out = psel_in & penable_in & ~addr_ok(paddr_in);

endmodule : audio_serial_port

// *** test/audio_serial_port_assertions.sv ***
// Pin timing checks for the audio serial port
`timescale 1ns/1ps
`include "audio_port_defs.svh"
module audio_serial_port_chk (
    // Clock, reset and register bus
    input wire logic        clk_in,
    input wire logic        sys_rst_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    // Link pins
    input wire logic        sck_out,
    input wire logic        sck_oe_out,
    input wire logic        ws_out,
    input wire logic        ws_oe_out,
    input wire logic        dout_out,
    input wire logic        dout_oe_out
);
    audio_port_pkg::ctrl_s c_r;
    logic [3:0]            age_r;
    logic [8:0]            fal_r;
    logic [8:0]            ris_r;
    logic [8:0]            frm_r;
    logic                  wrc;
    logic                  mi2s;
    logic                  mpcm;
    assign wrc  = psel_in & penable_in & pwrite_in
                & (paddr_in == `AP_CTRL_OFF);
    assign mi2s = c_r.en & c_r.master & ~c_r.pcm & (age_r == 4'hf);
    assign mpcm = c_r.en & c_r.master & c_r.pcm & (age_r == 4'hf);
    // Shadow of the control word and bit clock edge counters
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || wrc) begin
            c_r   <= sys_rst_in ? '0
                   : audio_port_pkg::ctrl_s'(pwdata_in[16:0]);
            age_r <= 4'h0;
            fal_r <= 9'h000;
            ris_r <= 9'h000;
            frm_r <= 9'h000;
        end else begin
            age_r <= age_r + {3'h0, age_r != 4'hf};
            if ($fell(sck_out))
                fal_r <= $changed(ws_out) ? 9'h001
                       : fal_r + {8'h00, fal_r != 9'h000};
            if ($rose(sck_out)) begin
                ris_r <= $rose(ws_out) ? 9'h001 : ris_r + {8'h00, ws_out};
                frm_r <= $rose(ws_out) ? 9'h001
                       : frm_r + {8'h00, frm_r != 9'h000};
            end
        end
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    chk_master_pins: assert property (age_r == 4'hf |->
        sck_oe_out == (c_r.en & c_r.master) && ws_oe_out == sck_oe_out)
        else $error("clock pin direction wrong for mode");
    chk_i2s_launch: assert property (mi2s && dout_oe_out &&
        $past(dout_oe_out) && $changed(dout_out) |-> $fell(sck_out))
        else $error("serial data changed away from falling clock");
    chk_ws_on_fall: assert property (mi2s && $changed(ws_out)
        |-> $fell(sck_out))
        else $error("word select changed away from falling clock");
    chk_ws_period: assert property (mi2s && $changed(ws_out)
        && fal_r != 9'h000 |-> fal_r == 9'h010)
        else $error("word select period is not sixteen bits");
    chk_pcm_release: assert property (mpcm && $fell(dout_oe_out)
        |-> $fell(sck_out))
        else $error("data driver released away from falling clock");
    chk_sync_rise: assert property (mpcm && $changed(ws_out)
        |-> $rose(sck_out))
        else $error("frame sync not aligned to rising clock");
    chk_sync_width: assert property (mpcm && $fell(ws_out)
        |-> ris_r == (c_r.long_sync ? 9'h003 : 9'h001))
        else $error("frame sync width wrong");
    chk_frame_len: assert property (mpcm && $rose(ws_out)
        && frm_r != 9'h000 |-> frm_r == (9'h010 << c_r.slots_lg))
        else $error("frame length wrong for slot count");
endmodule : audio_serial_port_chk

bind audio_serial_port audio_serial_port_chk chk_u (
    .clk_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .sck_out, .sck_oe_out, .ws_out, .ws_oe_out, .dout_out,
    .dout_oe_out);

// *** test/codec_model.sv ***
// Codec model at the far end of the I2S link
`timescale 1ns/1ps
module codec_model #(
    parameter logic [15:0] L_WORD = 16'h8421,
    parameter logic [15:0] R_WORD = 16'h1e3c
) (
    // Link lines
    input  wire logic        drive_in,
    input  wire logic        sck_in,
    input  wire logic        ws_in,
    input  wire logic        dout_in,
    output logic             din_out = 1'b0,
    output logic             sck_out = 1'b0,
    output logic             ws_out = 1'b0,
    // Received words
    output logic             got_out = 1'b0,
    output logic      [15:0] left_out = 16'h0000,
    output logic      [15:0] right_out = 16'h0000
);
    logic [15:0] rx_sr = 16'h0000;
    logic [15:0] tx_sr = 16'h0000;
    logic [3:0]  cnt = 4'h0;
    logic [1:0]  seen = 2'h0;
    logic        ws_p = 1'b0;
    // Bit clock runs only while driving, phase unrelated to system clock
    initial begin
        #7;
        forever begin
            #80;
            if (drive_in)
                sck_out = ~sck_out;
        end
    end
    always @(sck_in) begin
        if (sck_in) begin
            got_out <= 1'b0;
            if (ws_in != ws_p) begin
                tx_sr <= ws_in ? R_WORD : L_WORD;
                seen  <= seen + {1'b0, seen != 2'h2};
                got_out <= ws_p & (seen == 2'h2);
                if (ws_p)
                    right_out <= {rx_sr[14:0], dout_in};
                else
                    left_out <= {rx_sr[14:0], dout_in};
            end
            rx_sr <= {rx_sr[14:0], dout_in};
            ws_p  <= ws_in;
        end else begin
            din_out <= tx_sr[15];
            tx_sr   <= {tx_sr[14:0], ~tx_sr[15]};
            if (drive_in) begin
                cnt <= cnt + 4'h1;
                if (cnt == 4'hf)
                    ws_out <= ~ws_out;
            end
        end
    end
endmodule : codec_model

// *** test/audio_serial_port_test.sv ***
// Self-checking bench for the audio serial port
`timescale 1ns/1ps
`include "audio_port_defs.svh"
module audio_serial_port_test;
    localparam logic [15:0] LW = 16'h8421;
    localparam logic [15:0] RW = 16'h1e3c;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic        drv = 1'b0;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd;
    logic        prdy, perr, sck_o, sck_oe, ws_o, ws_oe, dout, dout_oe;
    logic        sck_l, ws_l, din, p_sck, p_ws, got;
    logic [15:0] lw, rw, t0, t1;
    logic [32:0] eq[$];
    logic [31:0] wq[$];
    logic [31:0] cfg[5] = '{32'h47, 32'h47, 32'h4f, 32'h57, 32'h127};
    int          n_errors = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          oe_n = 0;
    int          seed = 46;
    assign sck_l = (sck_oe === 1'b1) ? sck_o : p_sck;
    assign ws_l  = (ws_oe === 1'b1) ? ws_o : p_ws;
    always #10 clk = ~clk;
    audio_serial_port #(.NB_HALF(8'h08), .BURST_HALF(8'h04)) dut_u (
        .clk_in(clk), .sys_rst_in(rst), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
        .pready_out(prdy), .pslverr_out(perr), .sck_in(sck_l),
        .sck_out(sck_o), .sck_oe_out(sck_oe), .ws_in(ws_l), .ws_out(ws_o),
        .ws_oe_out(ws_oe), .din_in(din), .dout_out(dout),
        .dout_oe_out(dout_oe));
    codec_model #(.L_WORD(LW), .R_WORD(RW)) codec_u (
        .drive_in(drv), .sck_in(sck_l), .ws_in(ws_l),
        .dout_in(dout_oe ? dout : ~dout),
        .din_out(din), .sck_out(p_sck), .ws_out(p_ws), .got_out(got),
        .left_out(lw), .right_out(rw));
    task automatic check(input logic [32:0] g, input logic [32:0] x);
        n_compared++;
        if (g !== x) begin
            n_errors++;
            $display("mismatch at %0t ns: got %h expected %h", $time, g, x);
        end
    endtask : check
    task automatic give_verdict();
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwr  <= w;
        pa   <= a;
        pwd  <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (prdy !== 1'b1);
        psel <= 1'b0;
        pen  <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [32:0] x);
        eq.push_back(x);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic frames();
        wq.push_back({t0, t1});
        wq.push_back({t0, t1});
        while (wq.size() > 0)
            @(posedge clk);
        rd(`AP_RX0_OFF, {17'h0, LW});
        rd(`AP_RX1_OFF, {17'h0, RW});
    endtask : frames
    // Bus answers and link words are matched against the oldest note
    always @(posedge clk) begin
        cyc++;
        if (dout_oe === 1'b1)
            oe_n++;
        if (psel && pen && prdy === 1'b1 && !pwr && eq.size() > 0)
            check({perr, prd}, eq.pop_front());
        if (cyc == 20000) begin
            n_errors++;
            give_verdict();
        end
    end
    always @(posedge got) begin
        if (wq.size() > 0)
            check({1'b0, lw, rw}, {1'b0, wq.pop_front()});
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`AP_CTRL_OFF, 33'h0);
        rd(`AP_MAP_OFF, 33'h0);
        rd(12'h030, 33'h100000000);
        apb(1'b1, `AP_STATUS_OFF, 32'hffffffff);
        rd(`AP_STATUS_OFF, 33'h0);
        t0 = 16'($random(seed));
        t1 = 16'($random(seed));
        apb(1'b1, `AP_TX0_OFF, {16'h0, t0});
        apb(1'b1, `AP_TX1_OFF, {16'h0, t1});
        rd(`AP_TX1_OFF, {17'h0, t1});
        apb(1'b1, `AP_CTRL_OFF, 32'h5);
        frames();
        apb(1'b1, `AP_CTRL_OFF, 32'h1);
        drv <= 1'b1;
        repeat (700) @(posedge clk);
        frames();
        drv <= 1'b0;
        foreach (cfg[i]) begin
            apb(1'b1, `AP_CTRL_OFF, 32'h0);
            apb(1'b1, `AP_MAP_OFF, (i == 0) ? 32'hf : 32'h11);
            apb(1'b1, `AP_CTRL_OFF, cfg[i]);
            oe_n = 0;
            repeat (1500) @(posedge clk);
            check({32'h0, oe_n != 0}, {32'h0, i != 0});
        end
        give_verdict();
    end
endmodule : audio_serial_port_test
